/* File: verilog/msoc_top.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module msoc_top
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic [msoc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [msoc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [msoc_pkg::DATA_W-1:0] regRdData,
	// Jack and de-bounce status
	input wire logic jackPresent,
	input wire logic insertEvent,
	input wire logic debounceBusy,
	// Detection engine
	input wire logic detectDone,
	input wire msoc_pkg::msoc_acc_type detectResult,
	output logic detectStart,
	// Switch drive and power
	output msoc_pkg::msoc_sw_type switchOut,
	output logic sleepMode
);
	import msoc_pkg::*;

	logic [DATA_W-1:0] devSet_reg;
	msoc_sw_type swCtl_reg;
	msoc_acc_type accType_reg;
	logic resultValid_reg;
	msoc_sw_type switchOut_reg;
	logic sleepMode_reg;
	logic [DATA_W-1:0] rdData_reg;
	logic [DATA_W-1:0] rdData_next;
	logic detBusy;
	logic doneOk;
	logic blocked;
	logic overrideOn;
	msoc_sw_type mapCfg;
	msoc_sw_type target;
	logic wrDevSet;

	assign overrideOn = devSet_reg[BIT_OVERRIDE];
	assign wrDevSet = regWr && (regAddr == ADDR_DEV_SET);
	assign doneOk = detectDone && detBusy;

	//----------------------------------------------------------------------
	// Detection sequencing and type mapping
	//----------------------------------------------------------------------
	msoc_detect_seq msoc_detect_seq_inst
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.jackPresent(jackPresent),
		.insertEvent(insertEvent),
		.debounceBusy(debounceBusy),
		.autoDetEn(devSet_reg[BIT_AUTO_DET]),
		.swDetReq(devSet_reg[BIT_SW_DET_REQ]),
		.detectDone(detectDone),
		.detectStart(detectStart),
		.detBusy(detBusy)
	);

	msoc_route_map msoc_route_map_inst
	(
		.accType(accType_reg),
		.cfg(mapCfg)
	);

	//----------------------------------------------------------------------
	// Settings registers
	//----------------------------------------------------------------------
	// Override bit held here
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			devSet_reg <= DEV_SET_RESET;
		else if (wrDevSet)
			devSet_reg <= regWrData & DEV_SET_WMASK;
		else if (doneOk)
			devSet_reg[BIT_SW_DET_REQ] <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			swCtl_reg <= '0;
		else if (regWr && regAddr == ADDR_SW_CTL1)
			swCtl_reg.route <= regWrData[5:0] & ROUTE_WMASK;
		else if (regWr && regAddr == ADDR_SW_CTL2)
			swCtl_reg.sense <= regWrData[3:0] & SENSE_WMASK;
	end

	//----------------------------------------------------------------------
	// Latest detection result
	//----------------------------------------------------------------------
	// Type bits update under override
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			accType_reg <= '0;
		else if (doneOk)
			accType_reg <= detectResult;
		else if (!jackPresent)
			accType_reg <= '0;
	end

	// No result until a detection ran
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			resultValid_reg <= 1'b0;
		else if (doneOk)
			resultValid_reg <= 1'b1;
		else if (!jackPresent)
			resultValid_reg <= 1'b0;
	end

	//----------------------------------------------------------------------
	// Switch routing
	//----------------------------------------------------------------------
	// Detection blocks updates
	assign blocked = detBusy || debounceBusy;

	always_comb
	begin
		if (overrideOn)
			target = swCtl_reg;
		else if (resultValid_reg)
			target = mapCfg;
		else
			target = SW_NO_INSERT;
		if (devSet_reg[BIT_RADIO_GND] && jackPresent)
		begin
			target.route.sleeveDepl = 1'b0;
			target.route.ring2Depl = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			switchOut_reg <= SW_NO_INSERT;
		else if (!blocked)
			switchOut_reg <= target;
	end

	// Wake on override, sleep on exit
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			sleepMode_reg <= 1'b1;
		else
			sleepMode_reg <= !jackPresent && !overrideOn;
	end

	//----------------------------------------------------------------------
	// Read port
	//----------------------------------------------------------------------
	always_comb
	begin
		rdData_next = '0;
		unique case (regAddr)
			ADDR_DEV_SET:
				rdData_next = devSet_reg;
			ADDR_SW_CTL1:
				rdData_next = {2'h0, swCtl_reg.route};
			ADDR_SW_CTL2:
				rdData_next = {4'h0, swCtl_reg.sense};
			ADDR_SW_STAT1:
				rdData_next = {2'h0, switchOut_reg.route};
			ADDR_SW_STAT2:
				rdData_next = {4'h0, switchOut_reg.sense};
			ADDR_ACC_STAT:
			begin
				rdData_next[BIT_INSERTED] = jackPresent;
				rdData_next[2:0] = accType_reg;
			end
			ADDR_MODE_STAT:
				rdData_next = {5'h00, blocked && (switchOut_reg != target), detBusy,
					sleepMode_reg};
			default:
				rdData_next = '0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rdData_reg <= '0;
		else if (regRd)
			rdData_reg <= rdData_next;
		else
			rdData_reg <= '0;
	end

	assign regRdData = rdData_reg;
	assign switchOut = switchOut_reg;
	assign sleepMode = sleepMode_reg;

endmodule
`default_nettype wire

/* File: inc/msoc_pkg.sv */
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Bit 6 of device settings set enters host override; cleared leaves it.
// - Insertion and type detection run the same with or without override.
// - Switches hold during any type detection; new values wait for its end.
// - Override updates also wait while any de-bounce period runs.
// - Unblocked, enabling override drives switches from the switch control registers.
// - Clearing override restores the latest detection result routing once unblocked.
// - Accessory present but never detected: clearing override restores no-insertion routing.
// - Sleep and override are active together only in the one cycle after override is set.
// - Auto detect off and no software request: insertion starts no detection.
// - Software request under override detects and updates type bits; switches stay.
// - Insertion detects if auto or requested; switches follow result or registers.
// - Radio ground-pass mode turns depletion switches off while an accessory is in.
// - Override wakes the block; clearing it with no accessory restores and sleeps.
package msoc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	//----------------------------------------------------------------------
	// Register offsets
	//----------------------------------------------------------------------
	localparam logic [7:0] ADDR_DEV_SET = 8'h04;
	localparam logic [7:0] ADDR_SW_CTL1 = 8'h07;
	localparam logic [7:0] ADDR_SW_CTL2 = 8'h08;
	localparam logic [7:0] ADDR_SW_STAT1 = 8'h09;
	localparam logic [7:0] ADDR_SW_STAT2 = 8'h0a;
	localparam logic [7:0] ADDR_ACC_STAT = 8'h0b;
	localparam logic [7:0] ADDR_MODE_STAT = 8'h10;

	//----------------------------------------------------------------------
	// Fields and reset values
	//----------------------------------------------------------------------
	localparam int BIT_OVERRIDE = 6;
	localparam int BIT_AUTO_DET = 5;
	localparam int BIT_SW_DET_REQ = 4;
	localparam int BIT_RADIO_GND = 3;
	localparam int BIT_INSERTED = 3;
	localparam logic [7:0] DEV_SET_RESET = 8'h23;
	localparam logic [7:0] DEV_SET_WMASK = 8'h7f;
	localparam logic [5:0] ROUTE_WMASK = 6'h3f;
	localparam logic [3:0] SENSE_WMASK = 4'hf;

	typedef struct packed {
		logic sleeveGnd;
		logic ring2Gnd;
		logic sleeveDepl;
		logic ring2Depl;
		logic micSw2;
		logic micSw1;
	} msoc_route_type;

	typedef struct packed {
		logic s3ps;
		logic s3pr;
		logic s3gs;
		logic s3gr;
	} msoc_sense_type;

	typedef struct packed {
		msoc_route_type route;
		msoc_sense_type sense;
	} msoc_sw_type;

	typedef struct packed {
		logic stdFour;
		logic altFour;
		logic threePole;
	} msoc_acc_type;

	//----------------------------------------------------------------------
	// Switch patterns per routing state
	//----------------------------------------------------------------------
	localparam msoc_sw_type SW_NO_INSERT = 10'h0c0;
	localparam msoc_sw_type SW_THREE_POLE = 10'h3c0;
	localparam msoc_sw_type SW_STD_FOUR = 10'h1d9;
	localparam msoc_sw_type SW_ALT_FOUR = 10'h2e6;

	typedef enum logic [2:0] {
		DET_IDLE = 3'b001,
		DET_START = 3'b010,
		DET_WAIT = 3'b100
	} msoc_det_state_type;

endpackage

/* File: verilog/msoc_route_map.sv */
`timescale 1ns/100ps
`default_nettype none
module msoc_route_map
(
	// Detection result
	input wire msoc_pkg::msoc_acc_type accType,
	// Switch pattern
	output msoc_pkg::msoc_sw_type cfg
);
	import msoc_pkg::*;

	always_comb
	begin
		if (accType.stdFour)
			cfg = SW_STD_FOUR;
		else if (accType.altFour)
			cfg = SW_ALT_FOUR;
		else if (accType.threePole)
			cfg = SW_THREE_POLE;
		else
			cfg = SW_NO_INSERT;
	end

endmodule
`default_nettype wire

/* File: verilog/msoc_detect_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module msoc_detect_seq
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Jack state
	input wire logic jackPresent,
	input wire logic insertEvent,
	input wire logic debounceBusy,
	// Requests
	input wire logic autoDetEn,
	input wire logic swDetReq,
	// Detection engine
	input wire logic detectDone,
	output logic detectStart,
	output logic detBusy
);
	import msoc_pkg::*;

	msoc_det_state_type state_reg;
	msoc_det_state_type state_next;
	logic pendAuto_reg;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			pendAuto_reg <= 1'b0;
		else if (insertEvent && autoDetEn)
			pendAuto_reg <= 1'b1;
		else if (!jackPresent || state_reg == DET_START)
			pendAuto_reg <= 1'b0;
	end

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			DET_IDLE:
				if (jackPresent && !debounceBusy && (pendAuto_reg || swDetReq))
					state_next = DET_START;
			DET_START:
				state_next = DET_WAIT;
			DET_WAIT:
				if (detectDone || !jackPresent)
					state_next = DET_IDLE;
			default:
				state_next = DET_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			state_reg <= DET_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			detectStart <= 1'b0;
			detBusy <= 1'b0;
		end
		else
		begin
			detectStart <= (state_next == DET_START);
			detBusy <= (state_next != DET_IDLE);
		end
	end

endmodule
`default_nettype wire

/* File: tb/msoc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module msoc_assertions
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic [msoc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [msoc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [msoc_pkg::DATA_W-1:0] regRdData,
	// Jack, detection and switches
	input wire logic jackPresent,
	input wire logic detectDone,
	input wire logic detectStart,
	input wire msoc_pkg::msoc_sw_type switchOut,
	input wire logic sleepMode
);
	import msoc_pkg::*;
	logic [7:0] ctlShadow_reg;
	logic [5:0] prevRoute_reg;
	logic ovrShadow_reg;
	// Override bit as last written
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			ovrShadow_reg <= DEV_SET_RESET[BIT_OVERRIDE];
		else if (regWr && regAddr == ADDR_DEV_SET)
			ovrShadow_reg <= regWrData[BIT_OVERRIDE];
	end
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			ctlShadow_reg <= 8'h00;
		else if (regWr && regAddr == ADDR_SW_CTL1)
			ctlShadow_reg <= regWrData & 8'h3f;
	end
	always_ff @(posedge ref_clk)
	begin
		prevRoute_reg <= switchOut.route;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_sleep_excl: assert property (jackPresent ##1 1'b1 |-> !sleepMode)
		else $error("sleep while accessory present");
	a_sleep_ovr: assert property (ovrShadow_reg ##1 1'b1 |-> !sleepMode)
		else $error("sleep while override on");
	a_start_pulse: assert property (detectStart |=> !detectStart)
		else $error("start pulse too long");
	a_hold_detect: assert property (detectStart ##1 (jackPresent && !detectDone)
		|-> $stable(switchOut))
		else $error("switches moved during detection");
	a_rd_idle: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data without read");
	a_ctl_back: assert property (regRd && regAddr == ADDR_SW_CTL1
		|=> regRdData == ctlShadow_reg)
		else $error("switch control readback");
	a_unmapped: assert property (regRd && regAddr == 8'h20 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_route_echo: assert property (regRd && regAddr == ADDR_SW_STAT1
		|=> regRdData == {2'b00, prevRoute_reg})
		else $error("switch status mismatch");
	a_mode_sleep: assert property (regRd && regAddr == ADDR_MODE_STAT
		|=> regRdData[0] == $past(sleepMode))
		else $error("mode status sleep bit");
	c_detect: cover property (detectStart);
	c_wake: cover property ($fell(sleepMode));
	c_status: cover property (regRd && regAddr == ADDR_SW_STAT1);
endmodule
bind msoc_top msoc_assertions msoc_assertions_inst (.ref_clk(ref_clk), .rstn(rstn),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .jackPresent(jackPresent), .detectDone(detectDone),
	.detectStart(detectStart), .switchOut(switchOut), .sleepMode(sleepMode));
`default_nettype wire

/* File: tb/msoc_det_model.sv */
`timescale 1ns/100ps
`default_nettype none
module msoc_det_model
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Scenario control
	input wire msoc_pkg::msoc_acc_type kind,
	input wire logic [7:0] lat,
	// Detection link
	input wire logic detectStart,
	output logic detectDone,
	output msoc_pkg::msoc_acc_type detectResult
);
	import msoc_pkg::*;
	logic [7:0] cnt_reg;
	// Result valid only with done
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_reg <= 8'h00;
			detectDone <= 1'b0;
			detectResult <= 3'h0;
		end
		else
		begin
			detectDone <= 1'b0;
			detectResult <= ~detectResult;
			if (detectStart)
				cnt_reg <= lat;
			else if (cnt_reg != 8'h00)
			begin
				cnt_reg <= cnt_reg - 8'h01;
				if (cnt_reg == 8'h01)
				begin
					detectDone <= 1'b1;
					detectResult <= kind;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/msoc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module msoc_top_tb;
	import msoc_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdData;
	logic jackPresent = 1'b0;
	logic insertEvent = 1'b0;
	logic debounceBusy = 1'b0;
	logic detectDone;
	logic detectStart;
	logic sleepMode;
	msoc_acc_type detectResult;
	msoc_acc_type kind = 3'h4;
	logic [7:0] lat = 8'h05;
	msoc_sw_type switchOut;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2 ref_clk = ~ref_clk;
	msoc_top msoc_top_inst (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.jackPresent(jackPresent), .insertEvent(insertEvent), .debounceBusy(debounceBusy),
		.detectDone(detectDone), .detectResult(detectResult), .detectStart(detectStart),
		.switchOut(switchOut), .sleepMode(sleepMode));
	msoc_det_model msoc_det_model_inst (.ref_clk(ref_clk), .rstn(rstn), .kind(kind),
		.lat(lat), .detectStart(detectStart), .detectDone(detectDone),
		.detectResult(detectResult));
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic note(input string what, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		note("read data", {2'b00, exp}, {2'b00, regRdData});
	endtask
	task automatic sw(input msoc_sw_type exp, input logic slp);
		repeat (3) @(posedge ref_clk);
		#1;
		note("switches", exp, switchOut);
		note("sleep", {9'h000, slp}, {9'h000, sleepMode});
	endtask
	task automatic jack(input logic on);
		@(posedge ref_clk);
		jackPresent <= on;
		insertEvent <= on;
		@(posedge ref_clk);
		insertEvent <= 1'b0;
	endtask
	task automatic waitFor(input bit start);
		do
		begin
			@(posedge ref_clk);
			#1;
		end
		while ((start ? detectStart : detectDone) !== 1'b1);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			test_done();
		end
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(ADDR_DEV_SET, DEV_SET_RESET);
		rd(ADDR_MODE_STAT, 8'h01);
		sw(SW_NO_INSERT, 1'b1);
		jack(1'b1);
		waitFor(1'b0);
		sw(SW_STD_FOUR, 1'b0);
		rd(ADDR_ACC_STAT, 8'h0c);
		jack(1'b0);
		sw(SW_NO_INSERT, 1'b1);
		wr(ADDR_DEV_SET, 8'h03);
		kind <= 3'h1;
		lat <= 8'h14;
		jack(1'b1);
		sw(SW_NO_INSERT, 1'b0);
		rd(ADDR_ACC_STAT, 8'h08);
		wr(ADDR_SW_CTL1, 8'hff);
		wr(ADDR_SW_CTL2, 8'hff);
		wr(ADDR_DEV_SET, 8'h43);
		sw(10'h3ff, 1'b0);
		rd(ADDR_SW_CTL1, 8'h3f);
		rd(ADDR_SW_STAT1, 8'h3f);
		rd(ADDR_SW_STAT2, 8'h0f);
		wr(ADDR_DEV_SET, 8'h03);
		sw(SW_NO_INSERT, 1'b0);
		wr(ADDR_DEV_SET, 8'h43);
		wr(ADDR_DEV_SET, 8'h53);
		waitFor(1'b1);
		wr(ADDR_SW_CTL1, 8'h00);
		sw(10'h3ff, 1'b0);
		waitFor(1'b0);
		sw(10'h00f, 1'b0);
		rd(ADDR_ACC_STAT, 8'h09);
		rd(ADDR_DEV_SET, 8'h43);
		wr(ADDR_DEV_SET, 8'h03);
		sw(SW_THREE_POLE, 1'b0);
		@(posedge ref_clk);
		debounceBusy <= 1'b1;
		wr(ADDR_DEV_SET, 8'h43);
		sw(SW_THREE_POLE, 1'b0);
		@(posedge ref_clk);
		debounceBusy <= 1'b0;
		sw(10'h00f, 1'b0);
		jack(1'b0);
		sw(10'h00f, 1'b0);
		wr(ADDR_DEV_SET, 8'h23);
		sw(SW_NO_INSERT, 1'b1);
		wr(ADDR_SW_CTL1, 8'h3f);
		wr(ADDR_DEV_SET, 8'h6b);
		sw(10'h3ff, 1'b0);
		kind <= 3'h2;
		jack(1'b1);
		waitFor(1'b0);
		sw(10'h33f, 1'b0);
		rd(ADDR_SW_STAT1, 8'h33);
		rd(ADDR_ACC_STAT, 8'h0a);
		rd(8'h20, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
